// file: hdl/sac_regs.vh
// constants for the converter control block
// Functional notes
// - result is a 10-bit code, zero is ground, all ones is reference minus one step
// - reference and channel selections only reach the converter while enabled
// - result right-justified by default, left-justified when left adjust set
// - reading the low byte locks result updates until the high byte is read
// - done flag still rises when a locked result is discarded
// - start bit begins one conversion, reads one throughout, cleared at finish
// - channel change during a conversion applies only afterwards
// - with auto trigger on, a trigger rising edge resets prescaler and starts
// - trigger edges during conversion ignored; a held high trigger does not restart
// - a flag used as trigger must be cleared by software before retriggering
// - done flag as trigger restarts immediately after completion; first needs start write
// - free running keeps the start bit reading one continuously
// - software start works with auto trigger on; start bit reads one in any conversion
// - prescaler runs while enabled, held reset while disabled, ratio from select
// - a written start begins at the next converter clock edge
// - normal conversion 13 converter cycles, first after enable 25 cycles
// - sample strobe at 1.5 cycles normally, 13.5 cycles on the first conversion
// - at completion write result, set done flag, clear start bit in single mode
// - auto triggered conversions sample 2 cycles into the conversion, 3 cycles after the trigger edge
// - differential auto trigger from non-done sources takes 25 cycles each time
// - converter stays disabled unless power reduction bit is zero
// - channel select also offers ground and bandgap as single-ended inputs
// - selections frozen from start, tracking resumes in the last cycle before done
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
`define SAC_RES_W 10
`define SAC_CONV_NORMAL 5'h0D
`define SAC_CONV_FIRST 5'h19
`define SAC_SH_NORMAL 5'h01
`define SAC_SH_FIRST 5'h0D
`define SAC_SH_AUTO 5'h02
`define SAC_TRIG_DONE 3'h0
`define SAC_CH_GND 5'h1F
`define SAC_CH_BANDGAP 5'h1E
`endif

// file: hdl/sac_fifo.v
// small synchronous fifo carrying converted results
`timescale 1ns/1ns
module sac_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // write side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // read side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire do_wr;
  wire do_rd;

  // honest full and empty
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o = mem_r[rp_r];
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;

  // storage
  always @(posedge mclk_i) begin
    if (do_wr) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // pointers and count
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// file: hdl/sac_ctrl.v
// conversion sequencer, prescaler, trigger and result path
`timescale 1ns/1ns
`include "sac_regs.vh"
module sac_ctrl #(
  parameter PS_W = 7,
  parameter FIFO_DEPTH = 8
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // control bits from software
  input wire converter_enable_i,
  input wire converter_power_reduction_i,
  input wire start_conversion_wr_i,
  input wire auto_trigger_enable_i,
  input wire [2:0] trigger_source_select_i,
  input wire [2:0] prescaler_select_i,
  input wire left_adjust_result_i,
  input wire [4:0] channel_select_i,
  input wire [1:0] reference_select_i,
  input wire differential_mode_i,
  input wire done_flag_clear_i,
  // trigger sources from pins or other blocks
  input wire [7:0] trigger_sources_i,
  // result byte reads
  input wire result_low_rd_i,
  input wire result_high_rd_i,
  // analog front end
  input wire [`SAC_RES_W-1:0] afe_code_i,
  output reg afe_enable_o,
  output reg afe_sample_o,
  output reg [4:0] afe_channel_o,
  output reg [1:0] afe_reference_o,
  // status
  output reg start_conversion_bit_o,
  output reg conversion_done_flag_o,
  output reg [7:0] result_high_byte_o,
  output reg [7:0] result_low_byte_o,
  // result stream
  output reg stream_valid_o,
  input wire stream_ready_i,
  output reg [`SAC_RES_W-1:0] stream_data_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  reg [1:0] state_r;
  reg [PS_W-1:0] ps_cnt_r;
  reg [4:0] cyc_r;
  reg first_r;
  reg auto_conv_r;
  reg lock_r;
  reg [7:0] trig_meta_r;
  reg [7:0] trig_sync_r;
  reg trg_prev_r;
  reg [4:0] conv_len_r;
  reg [4:0] sh_cyc_r;
  reg sh_half_r;
  wire enabled;
  wire adc_tick;
  wire sel_trig;
  wire trig_edge;
  wire [`SAC_RES_W-1:0] code;
  wire done_now;
  wire ff_in_ready;
  wire ff_out_valid;
  wire [`SAC_RES_W-1:0] ff_out_data;
  wire ff_pop;
  reg [PS_W-1:0] ps_mask;

  // module is on only when not power-reduced
  assign enabled = converter_enable_i & ~converter_power_reduction_i;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // division ratio as a power of two mask
  always @* begin
    case (prescaler_select_i)
      3'h0, 3'h1: ps_mask = 7'h01;
      3'h2: ps_mask = 7'h03;
      3'h3: ps_mask = 7'h07;
      3'h4: ps_mask = 7'h0F;
      3'h5: ps_mask = 7'h1F;
      3'h6: ps_mask = 7'h3F;
      default: ps_mask = 7'h7F;
    endcase
  end
  // converter clock enable: last count of each period
  assign adc_tick = enabled & ((ps_cnt_r & ps_mask) == ps_mask);

  // ----------------------------------------------------------------
  // trigger synchronisation
  // ----------------------------------------------------------------
  // two stage synchroniser on every source
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_meta_r <= 8'h00;
      trig_sync_r <= 8'h00;
      trg_prev_r <= 1'b0;
    end else begin
      trig_meta_r <= trigger_sources_i;
      trig_sync_r <= trig_meta_r;
      trg_prev_r <= sel_trig;
    end
  end
  // done flag source uses the internal flag directly
  assign sel_trig = (trigger_source_select_i == `SAC_TRIG_DONE) ? conversion_done_flag_o :
    trig_sync_r[trigger_source_select_i];
  // done flag source restarts from the sequencer only, never from an idle edge
  assign trig_edge = auto_trigger_enable_i & enabled & sel_trig & ~trg_prev_r &
    (trigger_source_select_i != `SAC_TRIG_DONE);

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  assign code = afe_code_i;
  assign done_now = (state_r == ST_CONV) & adc_tick & (cyc_r == conv_len_r - 5'h01);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      ps_cnt_r <= {PS_W{1'b0}};
      cyc_r <= 5'h00;
      first_r <= 1'b1;
      auto_conv_r <= 1'b0;
      lock_r <= 1'b0;
      conv_len_r <= `SAC_CONV_NORMAL;
      sh_cyc_r <= `SAC_SH_NORMAL;
      sh_half_r <= 1'b1;
      afe_enable_o <= 1'b0;
      afe_sample_o <= 1'b0;
      afe_channel_o <= 5'h00;
      afe_reference_o <= 2'h0;
      start_conversion_bit_o <= 1'b0;
      conversion_done_flag_o <= 1'b0;
      result_high_byte_o <= 8'h00;
      result_low_byte_o <= 8'h00;
    end else begin
      afe_enable_o <= enabled;
      afe_sample_o <= 1'b0;
      // prescaler held reset while disabled or on a trigger edge in idle
      if (!enabled || (trig_edge && state_r == ST_IDLE)) begin
        ps_cnt_r <= {PS_W{1'b0}};
      end else begin
        ps_cnt_r <= ps_cnt_r + 1'b1;
      end
      if (!enabled) begin
        first_r <= 1'b1;
      end
      // selections track only while enabled and not mid conversion
      if (enabled && (state_r != ST_CONV || done_now)) begin
        afe_channel_o <= channel_select_i;
        afe_reference_o <= reference_select_i;
      end
      // result byte lock: low read locks, high read unlocks
      if (result_high_rd_i) begin
        lock_r <= 1'b0;
      end else if (result_low_rd_i) begin
        lock_r <= 1'b1;
      end
      // done flag: set wins over clear
      if (done_now) begin
        conversion_done_flag_o <= 1'b1;
      end else if (done_flag_clear_i) begin
        conversion_done_flag_o <= 1'b0;
      end
      if (start_conversion_wr_i && enabled) begin
        start_conversion_bit_o <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (enabled && (start_conversion_wr_i || trig_edge)) begin
            state_r <= ST_WAIT;
            start_conversion_bit_o <= 1'b1;
            auto_conv_r <= trig_edge & ~start_conversion_wr_i;
          end
        end
        ST_WAIT: begin
          if (!enabled) begin
            state_r <= ST_IDLE;
          end else if (adc_tick) begin
            state_r <= ST_CONV;
            cyc_r <= 5'h00;
            first_r <= 1'b0;
            if (first_r || (auto_conv_r && differential_mode_i &&
                trigger_source_select_i != `SAC_TRIG_DONE)) begin
              conv_len_r <= `SAC_CONV_FIRST;
              sh_cyc_r <= `SAC_SH_FIRST;
              sh_half_r <= 1'b1;
            end else if (auto_conv_r) begin
              conv_len_r <= `SAC_CONV_NORMAL;
              sh_cyc_r <= `SAC_SH_AUTO;
              sh_half_r <= 1'b0;
            end else begin
              conv_len_r <= `SAC_CONV_NORMAL;
              sh_cyc_r <= `SAC_SH_NORMAL;
              sh_half_r <= 1'b1;
            end
          end
        end
        ST_CONV: begin
          if (!enabled) begin
            state_r <= ST_IDLE;
            start_conversion_bit_o <= 1'b0;
          end else begin
            if (adc_tick) begin
              cyc_r <= cyc_r + 5'h01;
            end
            // sample strobe at the programmed point, counted within one prescaler period
            if (cyc_r == sh_cyc_r && ((sh_half_r && (ps_cnt_r & ps_mask) == (ps_mask >> 1)) ||
                (!sh_half_r && (ps_cnt_r & ps_mask) == {PS_W{1'b0}}))) begin
              afe_sample_o <= 1'b1;
            end
            if (done_now) begin
              if (!lock_r || result_high_rd_i) begin
                // justification
                if (left_adjust_result_i) begin
                  result_high_byte_o <= code[9:2];
                  result_low_byte_o <= {code[1:0], 6'h00};
                end else begin
                  result_high_byte_o <= {6'h00, code[9:8]};
                  result_low_byte_o <= code[7:0];
                end
              end
              if (auto_trigger_enable_i && trigger_source_select_i == `SAC_TRIG_DONE) begin
                state_r <= ST_CONV;
                cyc_r <= 5'h00;
                auto_conv_r <= 1'b0;
                conv_len_r <= `SAC_CONV_NORMAL;
                sh_cyc_r <= `SAC_SH_NORMAL;
                sh_half_r <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
                start_conversion_bit_o <= 1'b0;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result stream through the fifo
  // ----------------------------------------------------------------
  sac_fifo #(
    .WIDTH(`SAC_RES_W),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(done_now),
    .in_ready_o(ff_in_ready),
    .in_data_i(code),
    .out_valid_o(ff_out_valid),
    .out_ready_i(~stream_valid_o | stream_ready_i),
    .out_data_o(ff_out_data)
  );
  assign ff_pop = ff_out_valid & (~stream_valid_o | stream_ready_i);

  // registered stream output stage
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stream_valid_o <= 1'b0;
      stream_data_o <= 10'h000;
    end else if (~stream_valid_o | stream_ready_i) begin
      stream_valid_o <= ff_out_valid;
      if (ff_pop) begin
        stream_data_o <= ff_out_data;
      end
    end
  end
endmodule

// file: verif/sac_ctrl_properties.sv
// port assertions for the converter control block
`timescale 1ns/1ns
module sac_ctrl_properties (
  // clock, reset and controls
  input wire mclk_i, input wire rst_n_i, input wire converter_enable_i,
  input wire converter_power_reduction_i, input wire start_conversion_wr_i,
  input wire auto_trigger_enable_i, input wire [2:0] prescaler_select_i,
  input wire left_adjust_result_i, input wire done_flag_clear_i,
  // watched outputs
  input wire afe_enable_o, input wire afe_sample_o, input wire [4:0] afe_channel_o,
  input wire start_conversion_bit_o, input wire conversion_done_flag_o,
  input wire [7:0] result_low_byte_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------
  // port relations
  // ----------------
  a_off_idle: assert property (
    (!converter_enable_i || converter_power_reduction_i)[*3] |-> !afe_enable_o)
    else $error("converter active while off");
  a_start_busy: assert property (
    start_conversion_wr_i && converter_enable_i && !converter_power_reduction_i && !start_conversion_bit_o
    |=> start_conversion_bit_o)
    else $error("start bit not raised");
  a_done_clr_start: assert property (
    $rose(conversion_done_flag_o) && !auto_trigger_enable_i |-> !start_conversion_bit_o)
    else $error("start bit kept at completion");
  a_chan_frozen: assert property (
    $rose(start_conversion_bit_o) && prescaler_select_i < 3'h2 |-> ##3 $stable(afe_channel_o)[*8])
    else $error("channel moved during conversion");
  a_sample_strobe: assert property (
    $rose(start_conversion_bit_o) && prescaler_select_i < 3'h2 |-> ##[1:40] afe_sample_o)
    else $error("no sample strobe");
  a_left_pack: assert property (
    $rose(conversion_done_flag_o) && left_adjust_result_i |-> result_low_byte_o[5:0] == 6'h00)
    else $error("left adjusted low byte wrong");
  a_done_sticky: assert property (
    conversion_done_flag_o && !done_flag_clear_i && !$past(done_flag_clear_i) |=> conversion_done_flag_o)
    else $error("done flag dropped");
  a_busy_bound: assert property (
    $rose(start_conversion_bit_o) && prescaler_select_i == 3'h0 && !auto_trigger_enable_i
    |-> ##[25:56] $fell(start_conversion_bit_o))
    else $error("conversion length wrong");
endmodule
bind sac_ctrl sac_ctrl_properties u_sac_ctrl_properties (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .converter_enable_i(converter_enable_i), .converter_power_reduction_i(converter_power_reduction_i),
  .start_conversion_wr_i(start_conversion_wr_i), .auto_trigger_enable_i(auto_trigger_enable_i),
  .prescaler_select_i(prescaler_select_i), .left_adjust_result_i(left_adjust_result_i),
  .done_flag_clear_i(done_flag_clear_i), .afe_enable_o(afe_enable_o), .afe_sample_o(afe_sample_o),
  .afe_channel_o(afe_channel_o), .start_conversion_bit_o(start_conversion_bit_o),
  .conversion_done_flag_o(conversion_done_flag_o), .result_low_byte_o(result_low_byte_o));

// file: verif/sac_afe_model.sv
// analog front end model returning a code tied to the channel
`timescale 1ns/1ns
module sac_afe_model (
  // clock
  input wire mclk_i,
  // converter side
  input wire afe_enable_i,
  input wire afe_sample_i,
  input wire [4:0] afe_channel_i,
  output reg [9:0] afe_code_o
);
  reg [9:0] held_r = 10'h000;
  // hold the sampled code, toggle garbage while powered off
  always @(posedge mclk_i) begin
    if (afe_sample_i)
      held_r <= (afe_channel_i == 5'h1F) ? 10'h000 : {afe_channel_i, afe_channel_i};
    afe_code_o <= afe_enable_i ? held_r : ~afe_code_o;
  end
  initial afe_code_o = 10'h000;
endmodule

// file: verif/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench;
  reg mclk_i = 0, rst_n_i = 0, en = 0, pr = 0, st = 0, ate = 0, lar = 0, clr = 0, rdl = 0, rdh = 0, rdy = 0, hold = 0;
  reg [2:0] ts = 0, ps = 0;
  reg [4:0] ch = 0, c;
  reg [7:0] trg = 0;
  reg [31:0] rs = 32'h09801AB6;
  reg dm = 0;
  reg [1:0] rf = 2'h2;
  wire aen, smp, sbit, done, sv;
  wire [4:0] ach;
  wire [7:0] rh, rl;
  wire [1:0] reference_pin;
  wire [9:0] code, sd;
  integer errors = 0, num_checks = 0, n, p, k, d, nn;
  reg [9:0] q[$];
  always #10 mclk_i = ~mclk_i;
  sac_ctrl u_sac_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .converter_enable_i(en),
    .converter_power_reduction_i(pr), .start_conversion_wr_i(st), .auto_trigger_enable_i(ate),
    .trigger_source_select_i(ts), .prescaler_select_i(ps), .left_adjust_result_i(lar),
    .channel_select_i(ch), .reference_select_i(rf), .differential_mode_i(dm),
    .done_flag_clear_i(clr), .trigger_sources_i(trg), .result_low_rd_i(rdl), .result_high_rd_i(rdh),
    .afe_code_i(code), .afe_enable_o(aen), .afe_sample_o(smp), .afe_channel_o(ach),
    .afe_reference_o(reference_pin), .start_conversion_bit_o(sbit), .conversion_done_flag_o(done),
    .result_high_byte_o(rh), .result_low_byte_o(rl), .stream_valid_o(sv), .stream_ready_i(rdy),
    .stream_data_o(sd));
  sac_afe_model u_sac_afe_model (.mclk_i(mclk_i), .afe_enable_i(aen), .afe_sample_i(smp),
    .afe_channel_i(ach), .afe_code_o(code));
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [9:0] cv(input [4:0] cc);
    cv = (cc == 5'h1F) ? 10'h000 : {cc, cc};
  endfunction
  task chk(input [19:0] seen, input [19:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer m);
    repeat (m) @(negedge mclk_i);
  endtask
  task go;
    begin
      st = 1;
      cyc(1);
      st = 0;
    end
  endtask
  task fclr;
    begin
      clr = 1;
      cyc(1);
      clr = 0;
    end
  endtask
  task wdone;
    while (!done && n < 9000) begin
      cyc(1);
      n = n + 1;
    end
  endtask
  // one software conversion, channel moved to c2 mid-way
  task single(input [4:0] c1, input [4:0] c2, input integer lo, input integer hi);
    begin
      ch = c1;
      fclr;
      go;
      cyc(6);
      chk(sbit, 1);
      ch = c2;
      n = 6;
      wdone;
      chk(n >= lo && n <= hi, 1);
      chk(sbit, 0);
      chk({rh, rl}, lar ? {cv(c1), 6'h00} : {6'h00, cv(c1)});
      chk(ach, c2);
      q.push_back(cv(c1));
    end
  endtask
  task report_and_stop;
    begin
      if (errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // random stream ready, held low while stalling
  always @(negedge mclk_i) begin
    rs <= xs(rs);
    rdy <= !hold && rs[0];
  end
  // stream watcher against the noted results
  always @(posedge mclk_i)
    if (sv && rdy) begin
      chk(q.size() > 0, 1);
      if (q.size() > 0)
        chk(sd, q.pop_front());
    end
  initial begin
    #1000000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    cyc(3);
    rst_n_i = 1;
    // disabled or powered down converter stays idle, selections not applied
    ch = 5'h07;
    go;
    cyc(60);
    chk({done, ach, reference_pin}, 0);
    en = 1;
    pr = 1;
    go;
    cyc(60);
    chk({aen, done, ach, reference_pin}, 0);
    pr = 0;
    // every prescaler code, first and normal length, both justifications
    for (p = 0; p < 8; p = p + 1) begin
      en = 0;
      cyc(2);
      ps = p;
      lar = p[0];
      en = 1;
      cyc(2);
      d = (p < 2) ? 2 : (1 << p);
      for (k = 0; k < 2; k = k + 1) begin
        c = {2'h0, rs[2:0]};
        nn = k ? 13 : 25;
        single(c, c, nn * d - 2, nn * d + d + 6);
      end
    end
    en = 0;
    cyc(2);
    ps = 0;
    lar = 0;
    en = 1;
    single(5'h1E, 5'h1E, 48, 62);
    chk({ach, reference_pin}, {5'h1E, rf});
    single(5'h05, 5'h02, 24, 36);
    single(5'h1F, 5'h1F, 24, 36);
    // trigger edge starts once; a second edge and a held level do not
    ate = 1;
    ts = 3;
    fclr;
    trg[3] = 1;
    cyc(10);
    trg[3] = 0;
    cyc(1);
    trg[3] = 1;
    n = 11;
    wdone;
    chk(n >= 26 && n <= 44, 1);
    q.push_back(cv(5'h1F));
    fclr;
    cyc(80);
    chk({sbit, done}, 0);
    trg[3] = 0;
    // differential auto trigger takes the long conversion every time
    dm = 1;
    cyc(4);
    trg[3] = 1;
    n = 0;
    wdone;
    chk(n >= 50 && n <= 60, 1);
    q.push_back(cv(5'h1F));
    fclr;
    trg[3] = 0;
    dm = 0;
    // done flag as trigger: continuous conversions while the stream stalls
    hold = 1;
    ts = 0;
    ch = 5'h03;
    go;
    repeat (150) begin
      cyc(1);
      chk(sbit, 1);
      if (done) begin
        q.push_back(cv(5'h03));
        fclr;
      end
    end
    ate = 0;
    if (done) begin
      q.push_back(cv(5'h03));
      fclr;
    end
    n = 0;
    wdone;
    chk(n <= 30, 1);
    q.push_back(cv(5'h03));
    chk(sv, 1);
    hold = 0;
    cyc(60);
    chk(q.size() == 0, 1);
    // low byte read locks the result until the high byte is read
    single(5'h06, 5'h06, 24, 36);
    rdl = 1;
    cyc(1);
    rdl = 0;
    ch = 5'h02;
    fclr;
    go;
    n = 0;
    wdone;
    chk({done, rh, rl}, {1'b1, 6'h00, cv(5'h06)});
    q.push_back(cv(5'h02));
    rdh = 1;
    cyc(1);
    rdh = 0;
    single(5'h02, 5'h02, 24, 36);
    cyc(60);
    chk(q.size() == 0, 1);
    report_and_stop;
  end
endmodule
